//--- core/otp_security_defines.svh
`ifndef OTP_SECURITY_DEFINES_SVH
`define OTP_SECURITY_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// array geometry
`define OTP_WORD_W           32
`define OTP_SECTORS          4
`define OTP_ROWS_PER_SECTOR  512
`define OTP_MAIN_WORDS       2048
`define OTP_REDUNDANT_ROWS   4
`define OTP_DEPTH            2053
`define OTP_IDX_W            12
`define OTP_COPY_W           11
`define OTP_LAST_MAIN        11'h7FF
`define OTP_SEC_ROW          12'h800
`define OTP_RED_FIRST        12'h801
`define OTP_RED_LAST         12'h804
`define OTP_SECTOR_LO        9
`define OTP_SECTOR_HI        10
`define OTP_PROG_CYCLES      4

////////////////////////////////////////////////////////////////////////////////
// programming port resource identifiers
`define OTP_PORT_ADDR_ID     32'h0010_0200
`define OTP_PORT_DATA_ID     32'h0020_0100
`define OTP_PORT_CTRL_ID     32'h0010_0300
`define OTP_PORT_ADDR_W      16
`define OTP_PORT_CTRL_W      16

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define REG_OTP_ADDR         8'h00
`define REG_OTP_DATA         8'h04
`define REG_OTP_CTRL         8'h08
`define REG_SECURITY         8'h0C
`define REG_STATUS           8'h10
`define REG_READ_WORD        8'h14
`define REG_PORT_ID_ADDR     8'h18
`define REG_PORT_ID_DATA     8'h1C
`define REG_PORT_ID_CTRL     8'h20

////////////////////////////////////////////////////////////////////////////////
// control and status fields
`define CTRL_PROG            0
`define CTRL_READ            1
`define STAT_LOADED          0
`define STAT_COPIED          1
`define STAT_BUSY            2
`define STAT_REFUSED         3

////////////////////////////////////////////////////////////////////////////////
// security register fields
`define SEC_JTAG_OFF         0
`define SEC_LINK_OFF         1
`define SEC_BOOT_OTP         5
`define SEC_REDUNDANT        7
`define SEC_SECTOR_LOCK0     8
`define SEC_MASTER_LOCK      12
`define SEC_JTAG_OTP_OFF     13
`define SEC_DEBUG_OFF        14
`define SEC_USER_LO          15
`define SEC_USER_HI          21
`define SEC_USERCODE_LO      22
`define SEC_USERCODE_HI      31

`define BOOT_SRC_OTP         3'h4

`endif

//--- core/otp_security_pkg.sv
`default_nettype none
`include "otp_security_defines.svh"

package otp_security_pkg;

  typedef enum logic [2:0] {
    PH_LOAD,
    PH_LOAD_WAIT,
    PH_COPY,
    PH_DRAIN,
    PH_RUN,
    PH_PROG,
    PH_READ,
    PH_READ_WAIT
  } otp_phase_t;

  typedef struct packed {
    otp_phase_t                  phase;
    logic [`OTP_WORD_W-1:0]      sec;
    logic                        loaded;
    logic [`OTP_COPY_W-1:0]      cnt;
    logic                        pend;
    logic [`OTP_COPY_W-1:0]      pend_addr;
    logic                        copy_valid;
    logic [`OTP_COPY_W-1:0]      copy_addr;
    logic [`OTP_WORD_W-1:0]      copy_data;
    logic                        copied;
    logic                        tile_run;
    logic [`OTP_PORT_ADDR_W-1:0] addr;
    logic [`OTP_WORD_W-1:0]      data;
    logic [`OTP_PORT_CTRL_W-1:0] ctrl;
    logic                        refused;
    logic [`OTP_WORD_W-1:0]      read_word;
    logic [7:0]                  prog_cnt;
    logic [`OTP_WORD_W-1:0]      rdata;
    logic [2:0]                  boot_source;
    logic                        boot_otp;
    logic                        jtag_en;
    logic                        jtag_otp_en;
    logic                        link_en;
    logic                        redund_en;
    logic                        dbg_out;
    logic                        dbg_oe;
    logic                        dbg_req;
  } otp_ctl_t;

endpackage : otp_security_pkg

`default_nettype wire

//--- core/otp_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module otp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : otp_sync2

`default_nettype wire

//--- core/otp_array.sv
`timescale 1ns/10ps
`default_nettype none
`include "otp_security_defines.svh"

module otp_array #(
  parameter int DEPTH = `OTP_DEPTH,
  parameter int AW    = `OTP_IDX_W,
  parameter int DW    = `OTP_WORD_W
) (
  input  wire logic          i_clk,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic          i_we,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  // erased fuses read as zero; set here so only the clocked process writes cells
  logic [DW-1:0] cells [DEPTH] = '{default: '0};

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      cells[i_addr] <= cells[i_addr] | i_wdata;
    end
    o_rdata <= cells[i_addr];
  end

endmodule : otp_array

`default_nettype wire

//--- core/otp_security_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "otp_security_defines.svh"

module otp_security_control #(
  parameter int PROG_CYCLES = `OTP_PROG_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  input  wire logic        i_reg_from_jtag,
  output logic      [31:0] o_reg_rdata,
  input  wire logic [1:0]  i_boot_mode_pins,
  input  wire logic        i_debug_pin_in,
  input  wire logic        i_debug_break,
  output logic             o_debug_pin_out,
  output logic             o_debug_pin_oe,
  output logic             o_debug_request,
  output logic             o_jtag_enable,
  output logic             o_jtag_otp_enable,
  output logic             o_link_access_enable,
  output logic             o_redundant_rows_enable,
  output logic             o_boot_from_otp,
  output logic      [2:0]  o_boot_source,
  output logic             o_copy_valid,
  output logic      [10:0] o_copy_addr,
  output logic      [31:0] o_copy_data,
  output logic             o_tile_run,
  output logic      [31:0] o_security,
  output logic      [9:0]  o_jtag_user_code
);

  ////////////////////////////////////////////////////////////////////////////
  otp_security_pkg::otp_ctl_t st;
  otp_security_pkg::otp_ctl_t next_st;

  logic [`OTP_IDX_W-1:0]  mem_addr;
  logic                   mem_we;
  logic [`OTP_WORD_W-1:0] mem_wdata;
  logic [`OTP_WORD_W-1:0] mem_rdata;
  logic [2:0]             pins_sync;
  logic                   jtag_blocked;
  logic                   wr_ctrl;
  logic                   prog_req;
  logic                   read_req;
  logic                   prog_ok;
  logic [`OTP_IDX_W-1:0]  tgt;
  logic [1:0]             tgt_sector;
  logic                   tgt_high_ok;

  // one private array per tile instance
  otp_array #(
    .DEPTH (`OTP_DEPTH),
    .AW    (`OTP_IDX_W),
    .DW    (`OTP_WORD_W)
  ) u_array (
    .i_clk   (i_ref_clk),
    .i_addr  (mem_addr),
    .i_we    (mem_we),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  otp_sync2 #(
    .WIDTH (3)
  ) u_pin_sync (
    .i_clk   (i_ref_clk),
    .i_rst   (i_rst),
    .i_async ({i_debug_pin_in, i_boot_mode_pins}),
    .o_sync  (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign jtag_blocked = i_reg_from_jtag &&
                        (st.sec[`SEC_JTAG_OFF] || st.sec[`SEC_JTAG_OTP_OFF]);
  assign wr_ctrl  = i_reg_write && (i_reg_addr == `REG_OTP_CTRL) && !jtag_blocked;
  assign prog_req = wr_ctrl && i_reg_wdata[`CTRL_PROG];
  assign read_req = wr_ctrl && i_reg_wdata[`CTRL_READ] && !i_reg_wdata[`CTRL_PROG];
  assign tgt      = st.addr[`OTP_IDX_W-1:0];
  assign tgt_sector  = tgt[`OTP_SECTOR_HI:`OTP_SECTOR_LO];
  assign tgt_high_ok = (st.addr[`OTP_PORT_ADDR_W-1:`OTP_IDX_W] == '0);

  // a target is writable only if no lock covers it
  always_comb begin
    prog_ok = 1'b0;
    if (!tgt_high_ok || st.sec[`SEC_MASTER_LOCK]) begin
      prog_ok = 1'b0;
    end else if (tgt < `OTP_SEC_ROW) begin
      prog_ok = !st.sec[`SEC_SECTOR_LOCK0 + int'(tgt_sector)];
    end else if (tgt == `OTP_SEC_ROW) begin
      prog_ok = 1'b1;
    end else if (tgt <= `OTP_RED_LAST) begin
      prog_ok = st.sec[`SEC_REDUNDANT];
    end else begin
      prog_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st   = st;
    mem_addr  = `OTP_SEC_ROW;
    mem_we    = 1'b0;
    mem_wdata = st.data;

    next_st.copy_valid = st.pend;
    next_st.copy_addr  = st.pend_addr;
    next_st.copy_data  = st.pend ? mem_rdata : '0;
    next_st.pend       = 1'b0;
    next_st.rdata      = '0;

    case (st.phase)
      otp_security_pkg::PH_LOAD: begin
        mem_addr      = `OTP_SEC_ROW;
        next_st.phase = otp_security_pkg::PH_LOAD_WAIT;
      end
      otp_security_pkg::PH_LOAD_WAIT: begin
        // protections take effect only from the loaded word
        next_st.sec         = mem_rdata;
        next_st.loaded      = 1'b1;
        next_st.jtag_en     = !mem_rdata[`SEC_JTAG_OFF];
        next_st.jtag_otp_en = !mem_rdata[`SEC_JTAG_OFF] &&
                              !mem_rdata[`SEC_JTAG_OTP_OFF];
        next_st.link_en     = !mem_rdata[`SEC_LINK_OFF];
        next_st.redund_en   = mem_rdata[`SEC_REDUNDANT];
        next_st.boot_otp    = mem_rdata[`SEC_BOOT_OTP];
        next_st.boot_source = mem_rdata[`SEC_BOOT_OTP] ? `BOOT_SRC_OTP
                                                       : {1'b0, pins_sync[1:0]};
        next_st.cnt         = '0;
        next_st.phase       = otp_security_pkg::PH_COPY;
      end
      otp_security_pkg::PH_COPY: begin
        // copy starts at word 0, which is the forced boot entry
        mem_addr          = {1'b0, st.cnt};
        next_st.pend      = 1'b1;
        next_st.pend_addr = st.cnt;
        next_st.cnt       = st.cnt + 1'b1;
        if (st.cnt == `OTP_LAST_MAIN) begin
          next_st.phase = otp_security_pkg::PH_DRAIN;
        end
      end
      otp_security_pkg::PH_DRAIN: begin
        // pins have not yet left the synchroniser at load time; take them now
        next_st.boot_source = st.sec[`SEC_BOOT_OTP] ? `BOOT_SRC_OTP
                                                    : {1'b0, pins_sync[1:0]};
        next_st.copied = 1'b1;
        next_st.phase  = otp_security_pkg::PH_RUN;
      end
      otp_security_pkg::PH_RUN: begin
        next_st.tile_run = st.copied;
        if (prog_req) begin
          if (prog_ok) begin
            next_st.prog_cnt = 8'(PROG_CYCLES - 1);
            next_st.phase    = otp_security_pkg::PH_PROG;
          end else begin
            next_st.refused = 1'b1;
          end
        end else if (read_req) begin
          if (tgt_high_ok && (tgt <= `OTP_RED_LAST) &&
              ((tgt < `OTP_RED_FIRST) || st.sec[`SEC_REDUNDANT])) begin
            next_st.phase = otp_security_pkg::PH_READ;
          end else begin
            next_st.refused = 1'b1;
          end
        end
      end
      otp_security_pkg::PH_PROG: begin
        // fuse burn lasts PROG_CYCLES; the OR keeps blown bits set
        mem_addr = tgt;
        if (st.prog_cnt == '0) begin
          mem_we        = 1'b1;
          next_st.phase = otp_security_pkg::PH_RUN;
        end else begin
          next_st.prog_cnt = st.prog_cnt - 1'b1;
        end
      end
      otp_security_pkg::PH_READ: begin
        mem_addr      = tgt;
        next_st.phase = otp_security_pkg::PH_READ_WAIT;
      end
      otp_security_pkg::PH_READ_WAIT: begin
        next_st.read_word = mem_rdata;
        next_st.phase     = otp_security_pkg::PH_RUN;
      end
      default: begin
        next_st.phase = otp_security_pkg::PH_LOAD;
      end
    endcase

    // register writes; the address and data ports only latch values
    if (i_reg_write && !jtag_blocked) begin
      case (i_reg_addr)
        `REG_OTP_ADDR: next_st.addr = i_reg_wdata[`OTP_PORT_ADDR_W-1:0];
        `REG_OTP_DATA: next_st.data = i_reg_wdata;
        `REG_OTP_CTRL: next_st.ctrl = i_reg_wdata[`OTP_PORT_CTRL_W-1:0];
        `REG_STATUS: begin
          // a refusal in the same cycle wins over the clear
          if (i_reg_wdata[`STAT_REFUSED] && !next_st.refused) begin
            next_st.refused = 1'b0;
          end else if (i_reg_wdata[`STAT_REFUSED] && st.refused &&
                       !(prog_req || read_req)) begin
            next_st.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // reads answer in the next cycle; unmapped and blocked reads give zero
    if (i_reg_read && !jtag_blocked) begin
      case (i_reg_addr)
        `REG_OTP_ADDR:     next_st.rdata = {16'h0000, st.addr};
        `REG_OTP_DATA:     next_st.rdata = st.data;
        `REG_OTP_CTRL:     next_st.rdata = {16'h0000, st.ctrl};
        `REG_SECURITY:     next_st.rdata = st.sec;
        `REG_STATUS:       next_st.rdata = {28'h000_0000, st.refused,
                                            (st.phase != otp_security_pkg::PH_RUN),
                                            st.copied, st.loaded};
        `REG_READ_WORD:    next_st.rdata = st.read_word;
        `REG_PORT_ID_ADDR: next_st.rdata = `OTP_PORT_ADDR_ID;
        `REG_PORT_ID_DATA: next_st.rdata = `OTP_PORT_DATA_ID;
        `REG_PORT_ID_CTRL: next_st.rdata = `OTP_PORT_CTRL_ID;
        default:           next_st.rdata = '0;
      endcase
    end

    // open-drain debug sync: only ever pulls low
    next_st.dbg_out = 1'b0;
    next_st.dbg_oe  = st.loaded && !st.sec[`SEC_DEBUG_OFF] && i_debug_break;
    next_st.dbg_req = st.loaded && !st.sec[`SEC_DEBUG_OFF] && !pins_sync[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset holds every gate closed until the load
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st       <= '0;
      st.phase <= otp_security_pkg::PH_LOAD;
    end else begin
      st <= next_st;
    end
  end

  assign o_reg_rdata             = st.rdata;
  assign o_debug_pin_out         = st.dbg_out;
  assign o_debug_pin_oe          = st.dbg_oe;
  assign o_debug_request         = st.dbg_req;
  assign o_jtag_enable           = st.jtag_en;
  assign o_jtag_otp_enable       = st.jtag_otp_en;
  assign o_link_access_enable    = st.link_en;
  assign o_redundant_rows_enable = st.redund_en;
  assign o_boot_from_otp         = st.boot_otp;
  assign o_boot_source           = st.boot_source;
  assign o_copy_valid            = st.copy_valid;
  assign o_copy_addr             = st.copy_addr;
  assign o_copy_data             = st.copy_data;
  assign o_tile_run              = st.tile_run;
  assign o_security              = st.sec;
  assign o_jtag_user_code        = st.sec[`SEC_USERCODE_HI:`SEC_USERCODE_LO];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_in_run;
    st.phase == otp_security_pkg::PH_RUN;
  endsequence

  sequence s_prog_start;
    s_in_run ##0 prog_req;
  endsequence

  sequence s_refused_next;
    ##1 (st.refused && st.phase == otp_security_pkg::PH_RUN);
  endsequence

  a_load_before_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(st.loaded) |-> st.sec == $past(mem_rdata))
    else $error("security word not taken from array");

  a_copy_before_run: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_tile_run) |-> st.copied && !o_copy_valid && $past(st.copied, 1))
    else $error("tile released before copy finished");

  a_jtag_gate_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_in_run |-> (o_jtag_enable == !st.sec[`SEC_JTAG_OFF]))
    else $error("jtag enable disagrees with security bit 0");

  a_link_gate_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_in_run |-> (o_link_access_enable == !st.sec[`SEC_LINK_OFF]))
    else $error("link access disagrees with security bit 1");

  a_boot_otp_forced: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st.loaded && st.sec[`SEC_BOOT_OTP]) |-> o_boot_from_otp &&
    (o_boot_source == `BOOT_SRC_OTP))
    else $error("secure boot not forced");

  a_boot_pins_taken: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ($rose(st.copied) && !st.sec[`SEC_BOOT_OTP]) |->
    (o_boot_source == {1'b0, $past(pins_sync[1:0])}))
    else $error("boot source not taken from settled pins");

  a_redundant_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_in_run |-> (o_redundant_rows_enable == st.sec[`SEC_REDUNDANT]))
    else $error("redundant rows disagree with security bit 7");

  a_sector_lock_refuse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_prog_start ##0 (tgt_high_ok && tgt < `OTP_SEC_ROW &&
    st.sec[`SEC_SECTOR_LOCK0 + int'(tgt_sector)]) |-> s_refused_next)
    else $error("locked sector accepted a program request");

  a_master_lock_refuse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_prog_start ##0 st.sec[`SEC_MASTER_LOCK] |-> s_refused_next ##1 !mem_we)
    else $error("master lock did not refuse programming");

  a_jtag_otp_block: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_reg_read && i_reg_from_jtag && st.sec[`SEC_JTAG_OTP_OFF]) |=>
    (o_reg_rdata == '0))
    else $error("jtag read returned data while blocked");

  a_debug_pin_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (st.loaded && st.sec[`SEC_DEBUG_OFF]) |=> !o_debug_pin_oe && !o_debug_request)
    else $error("debug pin used while disabled");

endmodule : otp_security_control

`default_nettype wire

//--- verification/tile_sram_model.sv
`timescale 1ns/10ps
`default_nettype none

module tile_sram_model (
  input  wire logic        i_clk,
  input  wire logic        i_copy_valid,
  input  wire logic [10:0] i_copy_addr,
  input  wire logic [31:0] i_copy_data,
  input  wire logic        i_dbg_oe,
  input  wire logic        i_dbg_out,
  input  wire logic        i_pull_low,
  output logic             o_dbg_pin
);
  logic [31:0] mem [0:2047];
  int          words = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // sram image built from the boot copy stream
  always @(posedge i_clk) begin
    if (i_copy_valid === 1'b1) begin
      mem[i_copy_addr] <= i_copy_data;
      words            <= words + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // open-drain sync wire with pull-up: any party pulling low wins
  assign o_dbg_pin = (i_dbg_oe ? i_dbg_out : 1'b1) & !i_pull_low;
endmodule : tile_sram_model

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int          PROG  = 4;
  localparam logic [31:0] SEC_A = 32'hA960_E1A2;
  logic        clk = 0, rst = 1, wr_s = 0, rd_s = 0, jt = 0, brk = 0, pull = 0, pin;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0]  pins = 2'h3;
  logic [31:0] rdata, copy_d, sec;
  logic        dbg_out, dbg_oe, dbg_req, jtag_en, jtag_otp, link_en, red_en, boot_otp;
  logic        copy_v, run;
  logic [2:0]  boot_src;
  logic [10:0] copy_a;
  logic [9:0]  ucode;
  int          bad_count = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  otp_security_control #(.PROG_CYCLES(PROG)) DUT (
    .i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr_s), .i_reg_read(rd_s), .i_reg_from_jtag(jt), .o_reg_rdata(rdata),
    .i_boot_mode_pins(pins), .i_debug_pin_in(pin), .i_debug_break(brk),
    .o_debug_pin_out(dbg_out), .o_debug_pin_oe(dbg_oe), .o_debug_request(dbg_req),
    .o_jtag_enable(jtag_en), .o_jtag_otp_enable(jtag_otp), .o_link_access_enable(link_en),
    .o_redundant_rows_enable(red_en), .o_boot_from_otp(boot_otp), .o_boot_source(boot_src),
    .o_copy_valid(copy_v), .o_copy_addr(copy_a), .o_copy_data(copy_d), .o_tile_run(run),
    .o_security(sec), .o_jtag_user_code(ucode));

  tile_sram_model sram (
    .i_clk(clk), .i_copy_valid(copy_v), .i_copy_addr(copy_a), .i_copy_data(copy_d),
    .i_dbg_oe(dbg_oe), .i_dbg_out(dbg_out), .i_pull_low(pull), .o_dbg_pin(pin));

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one gap cycle between accesses so no strobe is driven twice in a step
  task bus(input logic w, input logic j, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    jt    <= j;
    wr_s  <= w;
    rd_s  <= !w;
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    jt   <= 1'b0;
  endtask : bus

  task rd(input logic j, input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, j, a, 32'h0000_0000);
    #1 chk(rdata, exp, what);
  endtask : rd

  task prog(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, 8'h00, {16'h0000, a});
    bus(1'b1, 1'b0, 8'h04, d);
    bus(1'b1, 1'b0, 8'h08, 32'h0000_0001);
    repeat (PROG + 4) @(posedge clk);
  endtask : prog

  task rdop(input logic [31:0] exp);
    bus(1'b1, 1'b0, 8'h08, 32'h0000_0002);
    repeat (4) @(posedge clk);
    rd(1'b0, 8'h14, exp, "read word");
  endtask : rdop

  task refused(input logic [31:0] exp);
    rd(1'b0, 8'h10, exp, "status");
    bus(1'b1, 1'b0, 8'h10, 32'h0000_0008);
  endtask : refused

  task boot;
    int n;
    n = 0;
    sram.words = 0;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    while (run !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1 chk(sram.words, 2048, "copy count");
    chk(run, 1'b1, "tile run");
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  task t_boot;
    boot();
    chk(sec, 32'h0000_0000, "security");
    chk(jtag_en, 1'b1, "jtag");
    chk(jtag_otp, 1'b1, "jtag otp");
    chk(link_en, 1'b1, "link");
    chk(boot_src, 3'h3, "pins boot");
    rd(1'b0, 8'h18, 32'h0010_0200, "addr id");
    rd(1'b0, 8'h1C, 32'h0020_0100, "data id");
    rd(1'b0, 8'h20, 32'h0010_0300, "ctrl id");
    rd(1'b1, 8'h18, 32'h0010_0200, "jtag read");
    $display("test boot done");
  endtask : t_boot

  task t_prog;
    prog(16'h0001, 32'h0000_00F0);
    rdop(32'h0000_00F0);
    prog(16'h0001, 32'h0000_000F);
    rdop(32'h0000_00FF);
    prog(16'h07FF, 32'h1234_5678);
    rdop(32'h1234_5678);
    prog(16'h0805, 32'h0000_0001);
    refused(32'h0000_000B);
    prog(16'h0801, 32'h0000_0001);
    refused(32'h0000_000B);
    rd(1'b0, 8'h10, 32'h0000_0003, "status clear");
    $display("test prog done");
  endtask : t_prog

  // inputs move only on a rising edge, by non-blocking assignment
  task t_debug(input logic en);
    @(posedge clk);
    brk <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(pin, !en, "pin driven");
    @(posedge clk);
    brk  <= 1'b0;
    pull <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(dbg_req, en, "pin request");
    @(posedge clk);
    pull <= 1'b0;
    repeat (6) @(posedge clk);
    $display("test debug done");
  endtask : t_debug

  task t_locks;
    prog(16'h0800, SEC_A);
    boot();
    chk(sec, SEC_A, "security");
    chk(link_en, 1'b0, "link");
    chk({boot_otp, boot_src}, 4'hC, "otp boot");
    chk(red_en, 1'b1, "redundant");
    chk(jtag_otp, 1'b0, "jtag otp");
    chk(jtag_en, 1'b1, "jtag");
    chk(ucode, 10'h2A5, "user code");
    chk(sram.mem[1], 32'h0000_00FF, "copied word");
    rd(1'b1, 8'h18, 32'h0000_0000, "jtag read");
    prog(16'h0000, 32'h0000_0001);
    refused(32'h0000_000B);
    prog(16'h0200, 32'h0000_0055);
    rdop(32'h0000_0055);
    bus(1'b1, 1'b1, 8'h00, 32'h0000_0123);
    rd(1'b0, 8'h00, 32'h0000_0200, "jtag write");
    prog(16'h0801, 32'h0000_0001);
    rd(1'b0, 8'h10, 32'h0000_0003, "status");
    rdop(32'h0000_0001);
    t_debug(1'b0);
    $display("test locks done");
  endtask : t_locks

  task t_master;
    prog(16'h0800, 32'h0000_1001);
    boot();
    chk(sec, SEC_A | 32'h0000_1001, "security");
    chk(jtag_en, 1'b0, "jtag");
    prog(16'h0400, 32'h0000_0001);
    refused(32'h0000_000B);
    rdop(32'h0000_0000);
    $display("test master done");
  endtask : t_master

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_boot();
    t_prog();
    t_debug(1'b1);
    t_locks();
    t_master();
    stop_test();
  end

  // three boots of about 2055 cycles plus short bus work
  initial begin
    repeat (40000) @(posedge clk);
    $display("[FAIL] %0t watchdog expired", $time);
    bad_count++;
    stop_test();
  end
endmodule : tb

`default_nettype wire
